// ==== include/scm_pkg.sv ====
package scm_pkg;

  localparam int SCM_NUM_SYNTH = 5;
  localparam int SCM_ADDR_W = 16;
  localparam int SCM_DATA_W = 8;
  localparam int SCM_MB_BYTES = 10;
  localparam int SCM_CFG_W = SCM_MB_BYTES * SCM_DATA_W;

  // register byte addresses
  localparam logic [15:0] SCM_SEL_LO_ADDR = 16'h0682;
  localparam logic [15:0] SCM_SEL_HI_ADDR = 16'h0683;
  localparam logic [15:0] SCM_CMD_ADDR = 16'h0684;
  localparam logic [15:0] SCM_MB_BASE_ADDR = 16'h0686;

  // selection field and command bits
  localparam int SCM_SEL_W = 5;
  localparam logic [15:0] SCM_SEL_RESET = 16'h0001;
  localparam int SCM_CMD_WR_BIT = 0;
  localparam int SCM_CMD_RD_BIT = 1;
  localparam logic [7:0] SCM_CMD_RESET = 8'h00;
  localparam logic [7:0] SCM_ZERO_BYTE = 8'h00;

  // one synthesizer configuration; lowest mailbox address holds the top byte
  typedef struct packed {
    logic [15:0] base_freq;
    logic [31:0] freq_mult;
    logic [15:0] freq_m;
    logic [15:0] freq_n;
  } scm_cfg_t;

  localparam scm_cfg_t SCM_CFG_RESET = '{
    base_freq: 16'h0001,
    freq_mult: 32'h12a05f20,
    freq_m: 16'h0001,
    freq_n: 16'h0001
  };

  // host byte access
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic [7:0] wdata;
  } scm_req_t;

  typedef enum logic [3:0] {
    SCM_IDLE = 4'b0001,
    SCM_APPLY = 4'b0010,
    SCM_FETCH = 4'b0100,
    SCM_DONE = 4'b1000
  } scm_state_t;

endpackage

// ==== logic/scm_slot.sv ====
`timescale 1ns/1ps
module scm_slot
  import scm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic load_in,
  input wire scm_cfg_t cfg_in,
  output scm_cfg_t cfg_out
);

  scm_cfg_t cfg_r;

  // whole configuration replaced on load
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_r <= SCM_CFG_RESET;
    end else if (load_in) begin
      cfg_r <= cfg_in;
    end
  end

  assign cfg_out = cfg_r;

endmodule // scm_slot

// ==== logic/scm_mailbox.sv ====
`timescale 1ns/1ps
// Operation
// R01 - write uses five-bit selection field
// R02 - selection bit index equals synthesizer index
// R03 - all selected synthesizers updated together
// R04 - host sets exactly one bit for read
// R05 - read trigger copies synthesizer into mailbox
// R06 - command reads zero when read done
// R07 - write trigger starts write when read clear
// R08 - write applies every mailbox setting
// R09 - write trigger cleared once write applied
// R10 - host selects mailbox page first
// R11 - mailbox carries base frequency and settings
// R12 - host waits for zero before changes
module scm_mailbox
  import scm_pkg::*;
#(
  parameter int NUM_SYNTH = SCM_NUM_SYNTH
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [SCM_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [SCM_DATA_W-1:0] reg_wdata_in,
  output logic [SCM_DATA_W-1:0] reg_rdata_out,
  output logic busy_out,
  output scm_cfg_t synth_cfg_out [NUM_SYNTH]
);

  scm_req_t req;
  scm_state_t state_r;
  scm_state_t state_nxt;
  logic [15:0] sel_r;
  logic [7:0] cmd_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic busy_r;
  logic [SCM_DATA_W-1:0] mb_r [SCM_MB_BYTES];
  logic [NUM_SYNTH-1:0] load_r;
  logic [SCM_CFG_W-1:0] mb_vec;
  logic [SCM_CFG_W-1:0] fetch_vec;
  scm_cfg_t slot_cfg [NUM_SYNTH];
  logic idle;
  logic wr_ok;
  logic cmd_hit;
  logic start_rd;
  logic start_wr;

  // bus access bundled for decode
  assign req = '{addr: reg_addr_in, wr: reg_wr_in, wdata: reg_wdata_in};
  assign idle = (state_r == SCM_IDLE);
  // host writes taken only while idle
  assign wr_ok = req.wr && idle;
  // command decode; read bit has priority
  assign cmd_hit = wr_ok && (req.addr == SCM_CMD_ADDR);
  assign start_rd = cmd_hit && req.wdata[SCM_CMD_RD_BIT]; // R05
  assign start_wr = cmd_hit && req.wdata[SCM_CMD_WR_BIT] && !req.wdata[SCM_CMD_RD_BIT]; // R07

  // mailbox bytes gathered into one configuration word
  always_comb begin
    mb_vec = '0;
    for (int i = 0; i < SCM_MB_BYTES; i++) begin
      mb_vec[(SCM_MB_BYTES-1-i)*SCM_DATA_W +: SCM_DATA_W] = mb_r[i]; // R11
    end
  end

  // lowest set selection bit picks the fetched synthesizer
  always_comb begin
    // no set bit leaves mailbox unchanged
    fetch_vec = mb_vec;
    for (int s = NUM_SYNTH - 1; s >= 0; s--) begin
      if (sel_r[s]) begin
        fetch_vec = slot_cfg[s]; // R02
      end
    end
  end

  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SCM_IDLE: begin
        if (start_rd) begin
          state_nxt = SCM_FETCH;
        end else if (start_wr) begin
          state_nxt = SCM_APPLY;
        end
      end
      SCM_APPLY: begin
        state_nxt = SCM_DONE;
      end
      SCM_FETCH: begin
        state_nxt = SCM_DONE;
      end
      SCM_DONE: begin
        state_nxt = SCM_IDLE;
      end
      default: begin
        state_nxt = SCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= SCM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // selection register; changes ignored while an operation runs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_r <= SCM_SEL_RESET;
    end else if (wr_ok) begin
      if (req.addr == SCM_SEL_LO_ADDR) begin
        sel_r[SCM_DATA_W-1:0] <= req.wdata; // R01
      end else if (req.addr == SCM_SEL_HI_ADDR) begin
        sel_r[2*SCM_DATA_W-1:SCM_DATA_W] <= req.wdata;
      end
    end
  end

  // command register: trigger bits held until the operation ends
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_r <= SCM_CMD_RESET;
    end else if (state_r == SCM_DONE) begin
      cmd_r <= SCM_CMD_RESET; // R06 R09
    end else if (start_rd) begin
      cmd_r <= SCM_CMD_RESET;
      cmd_r[SCM_CMD_RD_BIT] <= 1'b1; // R05
    end else if (start_wr) begin
      cmd_r <= SCM_CMD_RESET;
      cmd_r[SCM_CMD_WR_BIT] <= 1'b1; // R07
    end
  end

  // mailbox page bytes: host writes when idle, fetch overwrites all
  generate
    for (genvar b = 0; b < SCM_MB_BYTES; b++) begin : g_mb
      localparam logic [15:0] BYTE_ADDR = SCM_MB_BASE_ADDR + 16'(b);
      localparam logic [SCM_CFG_W-1:0] RST_VEC = SCM_CFG_RESET;
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          mb_r[b] <= RST_VEC[(SCM_MB_BYTES-1-b)*SCM_DATA_W +: SCM_DATA_W];
        end else if (state_r == SCM_FETCH) begin
          mb_r[b] <= fetch_vec[(SCM_MB_BYTES-1-b)*SCM_DATA_W +: SCM_DATA_W]; // R05
        end else if (wr_ok && (req.addr == BYTE_ADDR)) begin
          mb_r[b] <= req.wdata; // R11
        end
      end
    end
  endgenerate

  // load strobes for every selected synthesizer at once
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      load_r <= '0;
    end else if (state_r == SCM_APPLY) begin
      load_r <= sel_r[NUM_SYNTH-1:0]; // R01 R03
    end else begin
      load_r <= '0;
    end
  end

  // per-synthesizer configuration store
  generate
    for (genvar s = 0; s < NUM_SYNTH; s++) begin : g_slot
      scm_slot u_slot (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .load_in(load_r[s]), // R02
        .cfg_in(scm_cfg_t'(mb_vec)), // R08
        .cfg_out(slot_cfg[s])
      );
      assign synth_cfg_out[s] = slot_cfg[s];
    end
  endgenerate

  // read data mux, registered
  always_comb begin
    rdata_nxt = SCM_ZERO_BYTE;
    if (reg_addr_in == SCM_SEL_LO_ADDR) begin
      rdata_nxt = SCM_DATA_W'(sel_r[SCM_SEL_W-1:0]); // R01
    end else if (reg_addr_in == SCM_SEL_HI_ADDR) begin
      rdata_nxt = SCM_ZERO_BYTE;
    end else if (reg_addr_in == SCM_CMD_ADDR) begin
      rdata_nxt = cmd_r; // R06 R09
    end else begin
      for (int i = 0; i < SCM_MB_BYTES; i++) begin
        if (reg_addr_in == SCM_MB_BASE_ADDR + 16'(i)) begin
          rdata_nxt = mb_r[i];
        end
      end
    end
  end

  // one cycle read latency
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= SCM_ZERO_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // busy high in every non-idle state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != SCM_IDLE);
    end
  end

  // outputs straight from flops
  assign reg_rdata_out = rdata_r;
  assign busy_out = busy_r;

endmodule // scm_mailbox

// ==== sim/scm_mailbox_checker.sv ====
`timescale 1ns/1ps
module scm_mailbox_checker
  import scm_pkg::*;
#(
  parameter int NUM_SYNTH = SCM_NUM_SYNTH
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [SCM_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [SCM_DATA_W-1:0] reg_wdata_in,
  input wire logic [SCM_DATA_W-1:0] reg_rdata_out,
  input wire logic busy_out,
  input wire scm_cfg_t synth_cfg_out [NUM_SYNTH]
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic trig = reg_wr_in && reg_addr_in == SCM_CMD_ADDR && reg_wdata_in[1:0] != 2'h0;
  a_trig_busy: assert property (!busy_out && trig |=> busy_out) else $error("no busy");
  a_busy_len: assert property ($rose(busy_out) |=> busy_out ##1 !busy_out) else $error("busy len");
  a_no_spur: assert property (!busy_out && !trig |=> !busy_out) else $error("stray busy");
  a_cmd_zero: assert property (!busy_out && !reg_wr_in && reg_addr_in == SCM_CMD_ADDR
    |=> reg_rdata_out == 8'h00) else $error("cmd not zero");
  a_cmd_pend: assert property ($rose(busy_out) && reg_addr_in == SCM_CMD_ADDR
    |=> reg_rdata_out[1:0] != 2'h0) else $error("cmd early zero");
  a_sel_hi: assert property (reg_addr_in == SCM_SEL_HI_ADDR |=> reg_rdata_out == 8'h00) else $error("sel hi");
  a_sel_lo: assert property (reg_addr_in == SCM_SEL_LO_ADDR |=> reg_rdata_out[7:5] == 3'h0) else $error("sel lo");
  a_cfg_first: assert property (!$stable(synth_cfg_out[0]) |-> $fell(busy_out)) else $error("cfg0");
  a_cfg_last: assert property (!$stable(synth_cfg_out[NUM_SYNTH-1]) |-> $fell(busy_out)) else $error("cfg4");
  c_done: cover property ($fell(busy_out));
  c_cfg: cover property (!$stable(synth_cfg_out[0]));
  c_rd: cover property (trig && reg_wdata_in[1]);
endmodule // scm_mailbox_checker

bind scm_mailbox scm_mailbox_checker #(.NUM_SYNTH(NUM_SYNTH)) i_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .busy_out(busy_out), .synth_cfg_out(synth_cfg_out));

// ==== sim/scm_host_model.sv ====
`timescale 1ns/1ps
module scm_host_model
  import scm_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [15:0] addr_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic rd_pend_out
);
  // flat byte addresses: page number above the low seven bits
  initial begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_pend_out = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wr_out = 1'b1;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  // page selector sits at the top offset of each page
  task automatic page(input logic [15:0] a);
    wr({a[15:7], 7'h7f}, 8'(a[15:7]));
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk_in);
    addr_out = a;
    rd_pend_out = 1'b1;
    @(negedge clk_in);
    rd_pend_out = 1'b0;
  endtask
  // wait for zero before anything else
  task automatic poll(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      addr_out = SCM_CMD_ADDR;
      @(posedge clk_in);
      #1 ok = rdata_in === 8'h00;
      @(negedge clk_in);
    end
  endtask
endmodule // scm_host_model

// ==== sim/scm_mailbox_tb_top.sv ====
`timescale 1ns/1ps
module scm_mailbox_tb_top;
  import scm_pkg::*;
  logic clk_in, reset_n_in, reg_wr_in, rd_pend, busy_out;
  logic [15:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  scm_cfg_t synth_cfg_out [SCM_NUM_SYNTH];
  scm_cfg_t cfg, exp_cfg;
  logic [7:0] exp_q[$];
  int miscompares, n_tests, seed;
  bit ok;
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  scm_mailbox #(.NUM_SYNTH(SCM_NUM_SYNTH)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .busy_out(busy_out), .synth_cfg_out(synth_cfg_out));
  scm_host_model i_host (.clk_in(clk_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
    .wr_out(reg_wr_in), .wdata_out(reg_wdata_in), .rd_pend_out(rd_pend));
  task automatic chk(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask
  task automatic chk_cfg(input scm_cfg_t c);
    for (int b = 0; b < SCM_MB_BYTES; b++) chk(SCM_MB_BASE_ADDR + 16'(b), c[SCM_CFG_W-1-8*b -: 8]);
  endtask
  task automatic op(input logic [7:0] sel, input logic [7:0] cmd);
    i_host.wr(SCM_SEL_LO_ADDR, sel);
    i_host.wr(SCM_CMD_ADDR, cmd);
    i_host.poll(ok);
    n_tests++;
    if (!ok) begin
      $display("[FAIL] %0t poll exp %h got %h", $time, 8'h00, reg_rdata_out);
      miscompares++;
    end
  endtask
  always @(posedge clk_in) begin
    if (rd_pend === 1'b1) begin
      #1;
      n_tests++;
      if (reg_rdata_out !== exp_q[0]) begin
        $display("[FAIL] %0t exp %h got %h", $time, exp_q[0], reg_rdata_out);
        miscompares++;
      end
      void'(exp_q.pop_front());
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    end_of_test();
  end
  initial begin
    seed = 47806;
    reset_n_in = 1'b0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    i_host.page(SCM_CMD_ADDR);
    chk(SCM_SEL_LO_ADDR, 8'h01);
    chk(SCM_SEL_HI_ADDR, 8'h00);
    chk(SCM_CMD_ADDR, 8'h00);
    chk(16'h0700, 8'h00);
    chk_cfg(SCM_CFG_RESET);
    cfg = 80'({$random(seed), $random(seed), $random(seed)});
    for (int b = 0; b < SCM_MB_BYTES; b++) i_host.wr(SCM_MB_BASE_ADDR + 16'(b), cfg[SCM_CFG_W-1-8*b -: 8]);
    i_host.wr(SCM_SEL_HI_ADDR, 8'hff);
    chk(SCM_SEL_HI_ADDR, 8'h00);
    i_host.wr(SCM_SEL_LO_ADDR, 8'hff);
    chk(SCM_SEL_LO_ADDR, 8'h1f);
    i_host.wr(SCM_CMD_ADDR, 8'h00);
    chk(SCM_CMD_ADDR, 8'h00);
    op(8'h15, 8'h01);
    foreach (synth_cfg_out[s]) begin
      exp_cfg = (s % 2 == 0) ? cfg : SCM_CFG_RESET;
      n_tests++;
      if (synth_cfg_out[s] !== exp_cfg) begin
        $display("[FAIL] %0t exp %h got %h", $time, exp_cfg, synth_cfg_out[s]);
        miscompares++;
      end
    end
    for (int i = 0; i < SCM_NUM_SYNTH; i++) begin
      op(8'h01 << i, 8'h02);
      chk_cfg(i % 2 == 0 ? cfg : SCM_CFG_RESET);
    end
    op(8'h02, 8'h03);
    chk_cfg(SCM_CFG_RESET);
    end_of_test();
  end
endmodule // scm_mailbox_tb_top
